// ===== include/bmc_pkg.sv
/*
  constants and carrier types for the biphase mark line codec.
  assumes a single 100 MHz ref_clk and an active-low asynchronous reset.
*/
package bmc_pkg;
  // =========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int BIT_RATE_KHZ = 300;
  localparam int UI_CYCLES = (CLK_MHZ * 1000) / BIT_RATE_KHZ;
  localparam int HALF_CYCLES = UI_CYCLES / 2;
  localparam int LOW_LEAD_CYCLES = HALF_CYCLES;
  localparam int THRESH_CYCLES = (UI_CYCLES * 3) / 4;
  localparam int TIMEOUT_CYCLES = UI_CYCLES * 2;
  localparam int CNT_W = 10;

  // =========================================================
  // transmit states
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_LEAD = 4'b0010,
    TX_BITS = 4'b0100,
    TX_CLOSE = 4'b1000
  } tx_state_t;

  // received bit carrier
  typedef struct packed {
    logic valid;
    logic data;
  } rx_bit_t;
endpackage

// ===== design/bmc_rx_decoder.sv
/*
  biphase mark decoder: measures intervals between line edges.
  assumes its input is already synchronised to ref_clk.
*/
`timescale 1ns/1ps
module bmc_rx_decoder
  import bmc_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic line_in, // synchronised line level
  input wire logic enable, // receive allowed
  output rx_bit_t bit_out, // decoded bit strobe
  output logic active // edges seen recently
);
  // =========================================================
  // edge timing
  logic prev_r;
  logic [CNT_W-1:0] cnt_r;
  logic half_r;
  logic edge_w;
  logic is_half_w;

  assign edge_w = line_in ^ prev_r;
  assign is_half_w = cnt_r < CNT_W'(THRESH_CYCLES);

  // interval counter and classifier
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r <= 1'b0;
      cnt_r <= '0;
      half_r <= 1'b0;
      bit_out <= '0;
      active <= 1'b0;
    end
    else
    begin
      prev_r <= line_in;
      bit_out <= '0;
      if (!enable)
      begin
        cnt_r <= '0;
        half_r <= 1'b0;
        active <= 1'b0;
      end
      else if (edge_w)
      begin
        cnt_r <= '0;
        // first edge after silence only starts timing, so a lost
        // leading edge costs the first bit
        if (active)
        begin
          if (!is_half_w)
          begin
            bit_out <= '{valid: 1'b1, data: 1'b0};
            half_r <= 1'b0;
          end
          else if (half_r)
          begin
            bit_out <= '{valid: 1'b1, data: 1'b1};
            half_r <= 1'b0;
          end
          else
            half_r <= 1'b1;
        end
        active <= 1'b1;
      end
      else if (cnt_r >= CNT_W'(TIMEOUT_CYCLES))
      begin
        active <= 1'b0;
        half_r <= 1'b0;
      end
      else
        cnt_r <= cnt_r + CNT_W'(1);
    end
  end
endmodule

// ===== design/bmc_line_codec.sv
/*
  biphase mark encoder and decoder on the configuration channel.
  assumes the core presents bits with valid/ready and that orientation
  is stable while a packet runs.
  the decoder listens only while the driver is released.
*/
`timescale 1ns/1ps
module bmc_line_codec
  import bmc_pkg::*;
(
  input wire logic ref_clk, // system clock 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic orient_b, // 1 selects line b
  input wire logic tx_valid, // core offers a bit
  input wire logic tx_data, // bit value
  input wire logic tx_last, // final bit of packet
  output logic tx_ready, // pulses the cycle after a bit is taken
  output logic tx_busy, // packet in progress
  output rx_bit_t rx_bit, // decoded bit strobe
  output logic rx_active, // receive activity
  input wire logic config_line_a_i, // pin a level in
  output logic config_line_a_o, // pin a level out
  output logic config_line_a_oe, // pin a drive enable
  input wire logic config_line_b_i, // pin b level in
  output logic config_line_b_o, // pin b level out
  output logic config_line_b_oe // pin b drive enable
);
  // =========================================================
  // transmit
  tx_state_t state_r;
  logic level_r;
  logic bit_r;
  logic last_r;
  logic [CNT_W-1:0] cnt_r;
  logic drive_w;
  logic start_w;
  logic lead_done_w;
  logic cell_end_w;
  logic mid_cell_w;
  logic close_done_w;
  logic take_w;

  // counter end points of each phase
  assign start_w = (state_r == TX_IDLE) && tx_valid && !tx_ready;
  assign lead_done_w = (state_r == TX_LEAD) && (cnt_r == CNT_W'(LOW_LEAD_CYCLES - 1));
  assign cell_end_w = (state_r == TX_BITS) && (cnt_r == CNT_W'(UI_CYCLES - 1));
  assign mid_cell_w = (state_r == TX_BITS) && bit_r && (cnt_r == CNT_W'(HALF_CYCLES - 1));
  assign close_done_w = (state_r == TX_CLOSE) && (cnt_r == CNT_W'(HALF_CYCLES - 1));
  // a bit is taken at lead end, and at a cell end unless the packet stops
  assign take_w = lead_done_w || (cell_end_w && !last_r && tx_valid);
  assign drive_w = (state_r != TX_IDLE);

  // encoder phase
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= TX_IDLE;
    else
    begin
      unique case (state_r)
        TX_IDLE:
        begin
          if (start_w)
            state_r <= TX_LEAD;
        end
        TX_LEAD:
        begin
          if (lead_done_w)
            state_r <= TX_BITS;
        end
        TX_BITS:
        begin
          // a marked last bit or an underrun ends the packet
          if (cell_end_w && (last_r || !tx_valid))
            state_r <= TX_CLOSE;
        end
        TX_CLOSE:
        begin
          // closing level has stood half a cell
          if (close_done_w)
            state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // phase counter, cleared at each phase end point
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else
    begin
      unique case (state_r)
        TX_IDLE:
          cnt_r <= '0;
        TX_LEAD:
          cnt_r <= lead_done_w ? '0 : cnt_r + CNT_W'(1);
        TX_BITS:
          cnt_r <= cell_end_w ? '0 : cnt_r + CNT_W'(1);
        TX_CLOSE:
          cnt_r <= close_done_w ? '0 : cnt_r + CNT_W'(1);
      endcase
    end
  end

  // line level: low lead, edge at each cell start, mid edge for a one
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      level_r <= 1'b0;
    else if (state_r == TX_IDLE)
      level_r <= 1'b0;
    else if (lead_done_w)
      level_r <= 1'b1;
    else if (state_r == TX_LEAD)
      level_r <= 1'b0;
    else if (cell_end_w)
      level_r <= ~level_r;
    else if (mid_cell_w)
      level_r <= ~level_r;
  end

  // bit and end marker held for the whole cell
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_r <= 1'b0;
      last_r <= 1'b0;
    end
    else if (take_w)
    begin
      bit_r <= tx_data;
      last_r <= tx_last;
    end
  end

  // one-cycle pulse for every bit taken
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_ready <= 1'b0;
    else
      tx_ready <= take_w;
  end

  // =========================================================
  // pad outputs, registered, selected pin only
  // pin a level and enable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_line_a_o <= 1'b0;
      config_line_a_oe <= 1'b0;
    end
    else
    begin
      config_line_a_o <= level_r & ~orient_b;
      config_line_a_oe <= drive_w & ~orient_b;
    end
  end

  // pin b level and enable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_line_b_o <= 1'b0;
      config_line_b_oe <= 1'b0;
    end
    else
    begin
      config_line_b_o <= level_r & orient_b;
      config_line_b_oe <= drive_w & orient_b;
    end
  end

  // busy mirrors the driver enable
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_busy <= 1'b0;
    else
      tx_busy <= drive_w;
  end

  // =========================================================
  // receive: synchronise both pins, then select one
  logic [1:0] sync_a_r;
  logic [1:0] sync_b_r;
  logic line_sel_w;

  // two-flop synchroniser, pin a
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_a_r <= 2'b00;
    else
      sync_a_r <= {sync_a_r[0], config_line_a_i};
  end

  // two-flop synchroniser, pin b
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_b_r <= 2'b00;
    else
      sync_b_r <= {sync_b_r[0], config_line_b_i};
  end

  // only the oriented pin feeds the decoder
  assign line_sel_w = orient_b ? sync_b_r[1] : sync_a_r[1];

  // decoder deaf while this side drives
  bmc_rx_decoder u_dec (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .line_in(line_sel_w),
    .enable(~drive_w),
    .bit_out(rx_bit),
    .active(rx_active)
  );
endmodule

// ===== sim/bmc_codec_sva.sv
/* port checker for the line codec.
   assumes a bind from the bench top file. */
`timescale 1ns/1ps
module bmc_codec_chk
  import bmc_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic orient_b, // pin select
  input wire logic tx_ready, // bit taken
  input wire logic tx_busy, // driving
  input wire logic config_line_a_o, // a level
  input wire logic config_line_a_oe, // a enable
  input wire logic config_line_b_o, // b level
  input wire logic config_line_b_oe // b enable
);
  // ==========
  // line properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_sel_a; config_line_a_oe |-> !orient_b; endproperty
  a_sel_a: assert property (p_sel_a) else $error("a on wrong pin");
  property p_sel_b; config_line_b_oe |-> orient_b; endproperty
  a_sel_b: assert property (p_sel_b) else $error("b on wrong pin");
  property p_lead_a; $rose(config_line_a_oe) |-> !config_line_a_o [*8]; endproperty
  a_lead_a: assert property (p_lead_a) else $error("a lead not low");
  property p_lead_b; $rose(config_line_b_oe) |-> !config_line_b_o [*8]; endproperty
  a_lead_b: assert property (p_lead_b) else $error("b lead not low");
  property p_busy; tx_busy == (config_line_a_oe | config_line_b_oe); endproperty
  a_busy: assert property (p_busy) else $error("enable off busy");
  property p_cell; config_line_a_oe && $changed(config_line_a_o) |=> $stable(config_line_a_o) [*8];
  endproperty
  a_cell: assert property (p_cell) else $error("a edges too close");
  property p_close; $fell(config_line_b_oe) |-> $past(config_line_b_o, 2) == $past(config_line_b_o, 8);
  endproperty
  a_close: assert property (p_close) else $error("b closing level short");
  property p_rdy; tx_ready |-> tx_busy ##1 !tx_ready [*8]; endproperty
  a_rdy: assert property (p_rdy) else $error("bit taken off frame");
endmodule

// ===== sim/bmc_far_port.sv
/* far port model: sends and decodes marked frames.
   assumes the bench resolves the wire, bias reads low. */
`timescale 1ns/1ps
module bmc_far_port
  import bmc_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic line, // wire level
  output logic drv_o = 0, // level out
  output logic drv_oe = 0, // enable
  output logic got = 0, // bit strobe
  output logic got_d = 0 // bit value
);
  int gap = 999;
  logic prev = 0;
  logic half = 0;
  // ==========
  // interval decoder, deaf while sending
  always @(posedge ref_clk)
  begin
    got <= 0;
    prev <= line;
    gap <= gap + 1;
    if (line != prev && !drv_oe)
    begin
      gap <= 1;
      got <= gap <= TIMEOUT_CYCLES && (gap >= THRESH_CYCLES || half);
      got_d <= gap < THRESH_CYCLES;
      half <= gap < THRESH_CYCLES && !half;
    end
  end
  // ==========
  // frame sender, skip drops the first edge
  task automatic send(input logic [15:0] b, input int n, input bit skip);
    @(posedge ref_clk) #1;
    drv_oe = 1;
    drv_o = 0;
    for (int i = 0; i <= n; i++)
    begin
      repeat (i ? UI_CYCLES - HALF_CYCLES : HALF_CYCLES) @(posedge ref_clk);
      #1 drv_o ^= !(skip && i == 0);
      if (i == n)
        break;
      repeat (HALF_CYCLES) @(posedge ref_clk);
      #1 drv_o ^= b[i];
    end
    repeat (HALF_CYCLES) @(posedge ref_clk);
    #1 drv_oe = 0;
  endtask
endmodule

// ===== sim/bmc_line_codec_tb.sv
/* bench for the line codec against the far port model.
   assumes checker and model files are compiled first. */
`timescale 1ns/1ps
module bmc_line_codec_tb
  import bmc_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, orient_b = 0;
  logic tx_valid = 0, tx_data = 0, tx_last = 0;
  logic tx_ready, tx_busy, rx_active, a_o, a_oe, b_o, b_oe;
  logic drv_o, drv_oe, got, got_d, line;
  rx_bit_t rx_bit;
  logic exp_q[$];
  logic [15:0] pay;
  int miscompares = 0, checks_done = 0, cyc = 0;
  // ==========
  // shared wire, released parties read low
  assign line = orient_b ? (b_oe ? b_o : drv_oe & drv_o) : (a_oe ? a_o : drv_oe & drv_o);
  bmc_line_codec uut (.ref_clk, .rst_n, .orient_b, .tx_valid, .tx_data, .tx_last, .tx_ready,
    .tx_busy, .rx_bit, .rx_active, .config_line_a_i(line & !orient_b), .config_line_a_o(a_o),
    .config_line_a_oe(a_oe), .config_line_b_i(line & orient_b), .config_line_b_o(b_o),
    .config_line_b_oe(b_oe));
  bmc_far_port far (.ref_clk, .line, .drv_o, .drv_oe, .got, .got_d);
  initial forever #5 ref_clk = ~ref_clk;
  // ==========
  // checks and closing
  task automatic chk(input string what, input logic e, input logic s);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %b got %b", what, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watcher and hang limit
  always @(posedge ref_clk)
  begin
    cyc++;
    if (got === 1'b1 || rx_bit.valid === 1'b1)
      chk("bit", exp_q.size() ? exp_q.pop_front() : 1'bx, got ? got_d : rx_bit.data);
    if (cyc > 40000)
    begin
      miscompares++;
      wrap_up;
    end
  end
  // ==========
  // core sends one packet from pay
  task automatic tx_pkt(input int n);
    int k;
    for (int i = 0; i < n; i++)
    begin
      tx_valid = 1;
      tx_data = pay[i];
      tx_last = i == n - 1;
      exp_q.push_back(pay[i]);
      k = 0;
      do
      begin
        @(posedge ref_clk);
        k++;
      end
      while (tx_ready !== 1'b1 && k < 600);
      #1;
    end
    tx_valid = 0;
    tx_last = 0;
  endtask
  // ==========
  // two sends, then two receives, one losing its first edge
  initial
  begin
    pay = $urandom(32'h78ee);
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1;
    for (int t = 0; t < 4; t++)
    begin
      orient_b = t[0];
      pay = $urandom;
      if (t < 2)
        tx_pkt(8 - t);
      else
      begin
        pay[0] = pay[0] & (t != 3);
        for (int i = t - 2; i < 8; i++)
          exp_q.push_back(pay[i]);
        far.send(pay, 8, t == 3);
        chk("active", 1'b1, rx_active);
      end
      for (int k = 0; k < 1000 && tx_busy !== 1'b0; k++)
        @(posedge ref_clk);
      // decoder goes idle one timeout after its last edge
      repeat (TIMEOUT_CYCLES + 8) @(posedge ref_clk);
      #1 chk("left", 1'b0, exp_q.size() != 0);
      chk("quiet", 1'b0, rx_active);
    end
    wrap_up;
  end
endmodule
bind bmc_line_codec bmc_codec_chk chk (.ref_clk, .rst_n, .orient_b, .tx_ready, .tx_busy,
  .config_line_a_o, .config_line_a_oe, .config_line_b_o, .config_line_b_oe);
